// ---- cmss_pkg.sv ----
package cmss_pkg;
  localparam int          CMSS_XLEN        = 32;
  localparam logic [31:0] CMSS_MASK_RESET  = 32'h0000_0000;
  localparam logic [31:0] CMSS_CTRL_RESET  = 32'h0000_0000;
  localparam int          CMSS_MASK_BIT    = 0;
  localparam int          CMSS_SPSEL_BIT   = 1;
  localparam logic [31:0] CMSS_SP_VEC_ADDR = 32'h0000_0000;
  localparam logic [31:0] CMSS_PRIV_BASE   = 32'hE000_0000;
  localparam logic [31:0] CMSS_PRIV_LAST   = 32'hE00F_FFFF;
  localparam logic [31:0] CMSS_CORE_LAST   = 32'hE00F_FFFF;
  localparam logic [1:0]  CMSS_SZ_BYTE     = 2'h0;
  localparam logic [1:0]  CMSS_SZ_HALF     = 2'h1;
  localparam logic [1:0]  CMSS_SZ_WORD     = 2'h2;

  typedef enum logic [1:0] {
    CMSS_SEL_MASK = 2'h0,
    CMSS_SEL_CTRL = 2'h1,
    CMSS_SEL_NONE = 2'h2
  } cmss_sel_e;

  typedef enum logic [1:0] {
    CMSS_ST_LOADSP = 2'h0,
    CMSS_ST_THREAD = 2'h1,
    CMSS_ST_HANDLR = 2'h3
  } cmss_state_e;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [1:0]  size;
    logic [31:0] wdata;
  } cmss_mem_s;
endpackage

// ---- cmss_lane.sv ----
`timescale 1ns/1ps
`default_nettype none
// little-endian lane steering for one store or one load
module cmss_lane
  import cmss_pkg::*;
(
  // request
  input  wire logic [1:0]  addrLow,
  input  wire logic [1:0]  size,
  input  wire logic [31:0] storeData,
  input  wire logic [31:0] busRead,
  // steered
  output logic      [31:0] busWrite,
  output logic      [3:0]  byteEn,
  output logic      [31:0] loadData,
  output logic             misaligned
);
  logic [4:0] shamt;

  always_comb begin
    shamt      = {addrLow, 3'h0};
    busWrite   = storeData << shamt;
    byteEn     = 4'h0;
    loadData   = 32'h0000_0000;
    misaligned = 1'b0;
    case (size)
      CMSS_SZ_BYTE: begin
        byteEn   = 4'h1 << addrLow;
        loadData = {24'h00_0000, 8'(busRead >> shamt)};
      end
      CMSS_SZ_HALF: begin
        byteEn     = 4'h3 << addrLow;
        misaligned = addrLow[0];
        loadData   = {16'h0000, 16'(busRead >> shamt)};
      end
      CMSS_SZ_WORD: begin
        byteEn     = 4'hF;
        misaligned = |addrLow;
        loadData   = busRead;
      end
      default: misaligned = 1'b1;
    endcase
  end
endmodule
`default_nettype wire

// ---- cmss_core_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module cmss_core_regs
  import cmss_pkg::*;
#(
  parameter int XLEN = CMSS_XLEN
)(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            nrst,
  // special register moves
  input  wire logic            srWrite,
  input  wire logic            srRead,
  input  wire cmss_sel_e       srSel,
  input  wire logic [XLEN-1:0] srWdata,
  input  wire logic            chgStateValid,
  input  wire logic            chgStateSetMask,
  // exception sequencing
  input  wire logic            excReq,
  input  wire logic            excCfgPrio,
  input  wire logic            excReturn,
  input  wire logic            retToThread,
  input  wire logic            retUseProcess,
  // data memory request
  input  wire cmss_mem_s       memReq,
  input  wire logic [XLEN-1:0] memRdata,
  // reset-time stack load
  input  wire logic            vecValid,
  input  wire logic [XLEN-1:0] vecData,
  // outputs
  output logic      [XLEN-1:0] srRdata,
  output logic                 excTake,
  output logic                 handlerMode,
  output logic                 useProcessSp,
  output logic      [XLEN-1:0] mainSpInit,
  output logic                 mainSpLoaded,
  output logic      [XLEN-1:0] vecAddr,
  output logic                 busValid,
  output logic      [XLEN-1:0] busAddr,
  output logic      [XLEN-1:0] busWdata,
  output logic      [3:0]      busBe,
  output logic      [XLEN-1:0] loadData,
  output logic                 accessFault
);
  cmss_state_e     state_reg, state_next;
  logic            mask_reg, mask_next;
  logic            spsel_reg, spsel_next;
  logic [XLEN-1:0] rd_reg, rd_next;
  logic            take_reg, take_next;
  logic [XLEN-1:0] mainSp_reg, mainSp_next;
  logic            mainSpOk_reg, mainSpOk_next;
  logic            hand_reg, hand_next;
  logic            useProc_reg, useProc_next;
  logic            bv_reg, bv_next;
  logic [XLEN-1:0] ba_reg, ba_next;
  logic [XLEN-1:0] bw_reg, bw_next;
  logic [3:0]      be_reg, be_next;
  logic [XLEN-1:0] ld_reg, ld_next;
  logic            flt_reg, flt_next;
  logic [XLEN-1:0] laneW, laneL;
  logic [3:0]      laneBe;
  logic            laneMis;
  logic            inPriv;

  cmss_lane u_lane (
    .addrLow   (memReq.addr[1:0]),
    .size      (memReq.size),
    .storeData (memReq.wdata),
    .busRead   (memRdata),
    .busWrite  (laneW),
    .byteEn    (laneBe),
    .loadData  (laneL),
    .misaligned(laneMis)
  );

  // private region only takes whole words; address map is fixed
  assign inPriv = (memReq.addr >= CMSS_PRIV_BASE) &&
                  (memReq.addr <= CMSS_PRIV_LAST);

  always_comb begin
    state_next  = state_reg;
    mask_next   = mask_reg;
    spsel_next  = spsel_reg;
    rd_next       = rd_reg;
    take_next     = 1'b0;
    mainSp_next   = mainSp_reg;
    mainSpOk_next = mainSpOk_reg;
    case (state_reg)
      CMSS_ST_LOADSP: begin
        // reset is handled outside Handler mode: stack load, then Thread
        if (vecValid) begin
          mainSp_next   = vecData;
          mainSpOk_next = 1'b1;
          state_next = CMSS_ST_THREAD;
        end
      end
      CMSS_ST_THREAD: begin
        if (srWrite && srSel == CMSS_SEL_CTRL)
          spsel_next = srWdata[CMSS_SPSEL_BIT];
        if (excReq && !(excCfgPrio && mask_reg)) begin
          take_next   = 1'b1;
          spsel_next  = 1'b0;
          state_next  = CMSS_ST_HANDLR;
        end
      end
      CMSS_ST_HANDLR: begin
        // software writes to the stack bit are dropped here
        if (excReq && !(excCfgPrio && mask_reg))
          take_next = 1'b1;
        if (excReturn && retToThread) begin
          spsel_next = retUseProcess;
          state_next = CMSS_ST_THREAD;
        end
      end
      default: state_next = CMSS_ST_LOADSP;
    endcase
    if (srWrite && srSel == CMSS_SEL_MASK)
      mask_next = srWdata[CMSS_MASK_BIT];
    if (chgStateValid)
      mask_next = chgStateSetMask;
    if (srRead) begin
      case (srSel)
        CMSS_SEL_MASK: rd_next = {{(XLEN-1){1'b0}}, mask_reg};
        CMSS_SEL_CTRL: rd_next = {{(XLEN-2){1'b0}},
                          spsel_reg && state_reg != CMSS_ST_HANDLR,
                          1'b0};
        default:       rd_next = '0;
      endcase
    end
    // mode outputs registered from the next state so they leave a flop
    hand_next    = (state_next == CMSS_ST_HANDLR);
    useProc_next = spsel_next && (state_next == CMSS_ST_THREAD);
  end

  always_comb begin
    bv_next  = 1'b0;
    ba_next  = ba_reg;
    bw_next  = bw_reg;
    be_next  = be_reg;
    ld_next  = laneL;
    flt_next = 1'b0;
    if (memReq.valid) begin
      if (laneMis || (inPriv && memReq.size != CMSS_SZ_WORD)) begin
        flt_next = 1'b1;
      end else begin
        bv_next = 1'b1;
        ba_next = memReq.addr;
        bw_next = laneW;
        be_next = laneBe;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg  <= CMSS_ST_LOADSP;
      mask_reg   <= CMSS_MASK_RESET[CMSS_MASK_BIT];
      spsel_reg  <= CMSS_CTRL_RESET[CMSS_SPSEL_BIT];
      rd_reg       <= '0;
      take_reg     <= 1'b0;
      mainSp_reg   <= '0;
      mainSpOk_reg <= 1'b0;
      hand_reg     <= 1'b0;
      useProc_reg  <= 1'b0;
      bv_reg     <= 1'b0;
      ba_reg     <= '0;
      bw_reg     <= '0;
      be_reg     <= 4'h0;
      ld_reg     <= '0;
      flt_reg    <= 1'b0;
    end else begin
      state_reg  <= state_next;
      mask_reg   <= mask_next;
      spsel_reg  <= spsel_next;
      rd_reg       <= rd_next;
      take_reg     <= take_next;
      mainSp_reg   <= mainSp_next;
      mainSpOk_reg <= mainSpOk_next;
      hand_reg     <= hand_next;
      useProc_reg  <= useProc_next;
      bv_reg     <= bv_next;
      ba_reg     <= ba_next;
      bw_reg     <= bw_next;
      be_reg     <= be_next;
      ld_reg     <= ld_next;
      flt_reg    <= flt_next;
    end
  end

  assign srRdata      = rd_reg;
  assign excTake      = take_reg;
  assign handlerMode  = hand_reg;
  // handler mode forces main stack whatever the bit holds
  assign useProcessSp = useProc_reg;
  assign mainSpInit   = mainSp_reg;
  assign mainSpLoaded = mainSpOk_reg;
  assign vecAddr      = XLEN'(CMSS_SP_VEC_ADDR);
  assign busValid     = bv_reg;
  assign busAddr      = ba_reg;
  assign busWdata     = bw_reg;
  assign busBe        = be_reg;
  assign loadData     = ld_reg;
  assign accessFault  = flt_reg;

  mask_blocks_a: assert property (@(posedge clk) disable iff (!nrst)
    (mask_reg && excReq && excCfgPrio) |=> !excTake)
    else $error("masked exception was taken");
  state_change_a: assert property (@(posedge clk) disable iff (!nrst)
    chgStateValid |=> mask_reg == $past(chgStateSetMask))
    else $error("change-state did not update mask");
  handler_reads_a: assert property (@(posedge clk) disable iff (!nrst)
    (srRead && srSel == CMSS_SEL_CTRL && handlerMode) |=> srRdata == '0)
    else $error("stack bit visible in handler");
  handler_main_a: assert property (@(posedge clk) disable iff (!nrst)
    handlerMode |-> !useProcessSp)
    else $error("process stack used in handler");
  entry_clears_a: assert property (@(posedge clk) disable iff (!nrst)
    ($rose(handlerMode) && excTake) |-> !spsel_reg)
    else $error("entry left stack bit set");
  thread_sel_a: assert property (@(posedge clk) disable iff (!nrst)
    (srWrite && srSel == CMSS_SEL_CTRL && state_reg == CMSS_ST_THREAD
     && !excReq) |=> useProcessSp == $past(srWdata[1]))
    else $error("thread stack select wrong");
  priv_word_a: assert property (@(posedge clk) disable iff (!nrst)
    (memReq.valid && inPriv && memReq.size != CMSS_SZ_WORD) |=> accessFault)
    else $error("narrow private access passed");
  reserved_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    $past(srRead) |-> srRdata[XLEN-1:2] == '0)
    else $error("reserved bits read nonzero");
endmodule
`default_nettype wire

// ---- test_core_mask_and_stack_select.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_core_mask_and_stack_select
  import cmss_pkg::*;
;
  logic        clk;
  logic        nrst;
  logic        srWrite, srRead, chgStateValid, chgStateSetMask;
  cmss_sel_e   srSel;
  logic [31:0] srWdata, memRdata, vecData;
  logic        excReq, excCfgPrio, excReturn, retToThread, retUseProcess;
  logic        vecValid;
  cmss_mem_s   memReq;
  logic [31:0] srRdata, mainSpInit, vecAddr, busAddr, busWdata, loadData;
  logic        excTake, handlerMode, useProcessSp, mainSpLoaded;
  logic        busValid, accessFault;
  logic [3:0]  busBe;
  int          failCount, checked, cycles;

  cmss_core_regs DUT (.clk(clk), .nrst(nrst), .srWrite(srWrite),
    .srRead(srRead), .srSel(srSel), .srWdata(srWdata),
    .chgStateValid(chgStateValid), .chgStateSetMask(chgStateSetMask),
    .excReq(excReq),
    .excCfgPrio(excCfgPrio), .excReturn(excReturn),
    .retToThread(retToThread), .retUseProcess(retUseProcess),
    .memReq(memReq), .memRdata(memRdata), .vecValid(vecValid),
    .vecData(vecData), .srRdata(srRdata), .excTake(excTake),
    .handlerMode(handlerMode), .useProcessSp(useProcessSp),
    .mainSpInit(mainSpInit), .mainSpLoaded(mainSpLoaded),
    .vecAddr(vecAddr), .busValid(busValid), .busAddr(busAddr),
    .busWdata(busWdata), .busBe(busBe), .loadData(loadData),
    .accessFault(accessFault));

  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic complete_run;
    $display("compares %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // the whole sequence needs well under a few hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      failCount++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failCount++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // each driver lets a falling edge pass before raising its strobe
  task automatic sr_write(input cmss_sel_e sel, input logic [31:0] d);
    @(negedge clk);
    srSel = sel; srWdata = d; srWrite = 1'b1;
    @(negedge clk);
    srWrite = 1'b0;
  endtask

  task automatic sr_read(input cmss_sel_e sel, input logic [31:0] exp);
    @(negedge clk);
    srSel = sel; srRead = 1'b1;
    @(negedge clk);
    srRead = 1'b0;
    chk(srRdata, exp);
  endtask

  task automatic chg_state(input logic setMask);
    @(negedge clk);
    chgStateSetMask = setMask; chgStateValid = 1'b1;
    @(negedge clk);
    chgStateValid = 1'b0;
  endtask

  task automatic exc(input logic cfg, input logic expTake);
    @(negedge clk);
    excCfgPrio = cfg; excReq = 1'b1;
    @(negedge clk);
    excReq = 1'b0;
    chk({31'h0, excTake}, {31'h0, expTake});
  endtask

  task automatic ret(input logic proc);
    @(negedge clk);
    excReturn = 1'b1; retToThread = 1'b1; retUseProcess = proc;
    @(negedge clk);
    excReturn = 1'b0;
    chk({30'h0, handlerMode, useProcessSp}, {30'h0, 1'b0, proc});
  endtask

  task automatic mem(input logic [31:0] a, input logic [1:0] sz,
                     input logic [3:0] be, input logic flt);
    @(negedge clk);
    memReq = '{valid: 1'b1, addr: a, size: sz, wdata: 32'h0000_00AB};
    memRdata = 32'h4433_2211;
    @(negedge clk);
    memReq.valid = 1'b0;
    chk({30'h0, busValid, accessFault}, {30'h0, ~flt, flt});
    if (!flt) begin
      chk({28'h0, busBe}, {28'h0, be});
      chk(busAddr, a);
    end
  endtask

  task automatic t_masks;
    sr_write(CMSS_SEL_MASK, 32'hFFFF_FFFF);
    sr_read(CMSS_SEL_MASK, 32'h0000_0001);
    exc(1'b1, 1'b0);
    exc(1'b0, 1'b1);
    ret(1'b0);
    chg_state(1'b0);
    sr_read(CMSS_SEL_MASK, 32'h0000_0000);
    chg_state(1'b1);
    sr_read(CMSS_SEL_MASK, 32'h0000_0001);
    sr_write(CMSS_SEL_MASK, 32'h0000_0000);
    exc(1'b1, 1'b1);
    ret(1'b0);
    $display("done: mask");
  endtask

  task automatic t_stack;
    sr_write(CMSS_SEL_CTRL, 32'hFFFF_FFFF);
    chk({31'h0, useProcessSp}, 32'h1);
    sr_read(CMSS_SEL_CTRL, 32'h0000_0002);
    exc(1'b1, 1'b1);
    chk({30'h0, handlerMode, useProcessSp}, 32'h2);
    sr_read(CMSS_SEL_CTRL, 32'h0000_0000);
    sr_write(CMSS_SEL_CTRL, 32'h0000_0002);
    chk({31'h0, useProcessSp}, 32'h0);
    ret(1'b1);
    sr_read(CMSS_SEL_CTRL, 32'h0000_0002);
    sr_write(CMSS_SEL_CTRL, 32'h0000_0000);
    chk({31'h0, useProcessSp}, 32'h0);
    $display("done: stack");
  endtask

  task automatic t_mem;
    mem(32'h2000_0001, CMSS_SZ_BYTE, 4'h2, 1'b0);
    chk({24'h0, loadData[7:0]}, 32'h22);
    chk({24'h0, busWdata[15:8]}, 32'hAB);
    mem(32'h2000_0002, CMSS_SZ_HALF, 4'hC, 1'b0);
    chk({16'h0, loadData[15:0]}, 32'h4433);
    mem(32'hFFFF_FFFC, CMSS_SZ_WORD, 4'hF, 1'b0);
    chk(loadData, 32'h4433_2211);
    mem(32'h2000_0002, CMSS_SZ_WORD, 4'h0, 1'b1);
    mem(CMSS_PRIV_BASE, CMSS_SZ_HALF, 4'h0, 1'b1);
    mem(CMSS_PRIV_LAST - 32'h3, CMSS_SZ_WORD, 4'hF, 1'b0);
    $display("done: memory");
  endtask

  initial begin
    nrst = 1'b0; srWrite = 1'b0; srRead = 1'b0; chgStateValid = 1'b0;
    chgStateSetMask = 1'b0; srSel = CMSS_SEL_MASK; srWdata = '0;
    excReq = 1'b0; excCfgPrio = 1'b0; excReturn = 1'b0;
    retToThread = 1'b0; retUseProcess = 1'b0; memReq = '0;
    memRdata = '0; vecValid = 1'b0; vecData = '0;
    failCount = 0; checked = 0; cycles = 0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    chk(vecAddr, CMSS_SP_VEC_ADDR);
    // no exception may be taken before the stack pointer is loaded
    exc(1'b0, 1'b0);
    vecData = 32'h2000_0400;
    vecValid = 1'b1;
    @(negedge clk);
    vecValid = 1'b0;
    chk(mainSpInit, 32'h2000_0400);
    chk({30'h0, mainSpLoaded, useProcessSp}, 32'h2);
    sr_read(CMSS_SEL_MASK, CMSS_MASK_RESET);
    sr_read(CMSS_SEL_CTRL, CMSS_CTRL_RESET);
    $display("done: reset");
    t_masks();
    t_stack();
    t_mem();
    complete_run();
  end
endmodule
`default_nettype wire
